// ==== dv/flash_reset_monitor.sv ====
// Checker on the pins joining the host and device ends of the reset link.
// Instantiated beside the interface; sees only pin levels, core_clk and rst.
`timescale 1ns/1ps
module flash_reset_monitor #(
    parameter int PWR_UP_CYCLES = flash_reset_pkg::POWER_UP_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic selectN,
    input wire logic warmInitN,
    input wire logic dataOutEnN
);
    import flash_reset_pkg::*;
    localparam int SAT = 100000;
    int pwrCnt_ff, highCnt_ff, lowCnt_ff, fallCnt_ff;
    int nxt_pwrCnt, nxt_highCnt, nxt_lowCnt, nxt_fallCnt;

    // Pin history counters; all but lowCnt_ff saturate so long runs never wrap
    always_comb
    begin
        nxt_pwrCnt  = (pwrCnt_ff < SAT) ? pwrCnt_ff + 1 : pwrCnt_ff;
        nxt_highCnt = warmInitN ? ((highCnt_ff < SAT) ? highCnt_ff + 1 : SAT) : 0;
        nxt_lowCnt  = warmInitN ? lowCnt_ff : ((highCnt_ff == 0) ? lowCnt_ff + 1 : 1);
        nxt_fallCnt = (!warmInitN && highCnt_ff != 0) ? 0 :
                      ((fallCnt_ff < SAT) ? fallCnt_ff + 1 : SAT);
    end

    // No pulse yet after reset counts as fully covered recovery
    always_ff @(posedge core_clk)
    begin
        pwrCnt_ff  <= rst ? 0 : nxt_pwrCnt;
        highCnt_ff <= rst ? 0 : nxt_highCnt;
        lowCnt_ff  <= rst ? WARM_RECOVERY_CYC : nxt_lowCnt;
        fallCnt_ff <= rst ? SAT : nxt_fallCnt;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_PWR_SELECT_HIGH: assert property ((pwrCnt_ff < POWER_UP_CYC) |-> selectN)
        else $error("select low during power-up");
    AST_COLD_QUIET: assert property ((pwrCnt_ff < PWR_UP_CYCLES) |-> dataOutEnN)
        else $error("device drove data during cold init");
    AST_SETUP_HIGH: assert property ($fell(warmInitN) && pwrCnt_ff >= POWER_UP_CYC
        |-> highCnt_ff >= REINIT_SETUP_CYC) else $error("reset pin high time too short");
    AST_SEL_HIGH_IN_RESET: assert property (!warmInitN |-> selectN)
        else $error("select low while reset pin low");
    AST_RELEASE_WAIT: assert property ($fell(selectN) |-> highCnt_ff >= RELEASE_CYC)
        else $error("select fell too soon after reset release");
    AST_PULSE_SUM: assert property ($fell(selectN)
        |-> lowCnt_ff + highCnt_ff >= WARM_RECOVERY_CYC) else $error("pulse plus delay short");
    AST_IDLE_RELEASED: assert property (selectN [*5] |-> dataOutEnN)
        else $error("data driven while not selected");
    AST_RECOVERY_TRISTATE: assert property ((fallCnt_ff >= 8
        && fallCnt_ff < WARM_RECOVERY_CYC) |-> dataOutEnN) else $error("driven in recovery");

    // Main scenarios reached
    CV_WARM: cover property ($fell(warmInitN));
    CV_SELECT: cover property ($fell(selectN));
    CV_DRIVE: cover property (!dataOutEnN);
endmodule

// ==== dv/testbench.sv ====
// Bench joining host and device ends, plus a bench-driven second device end.
// Assumes the package cycle counts and a 20 MHz core_clk.
`timescale 1ns/1ps
module testbench;
    import flash_reset_pkg::*;
    localparam int PWR   = 40;
    localparam int LIMIT = 12000;
    logic core_clk, rst, rst2, supplyOk, coldFail, coldFail2, holdInit;
    logic selReq, warmReq, driveReq, driveBit;
    wire  hostReady, readData, opReady, inReset, regsRestored, selActive;
    wire  opReady2, inReset2, regsRestored2, selActive2;
    int   mismatches, comparisons, cycles;

    flash_reset_if link ();
    flash_reset_if bad ();
    flash_reset_host flash_reset_host_i (.core_clk(core_clk), .rst(rst), .holdInit(holdInit),
        .selReq(selReq), .warmReq(warmReq), .hostReady(hostReady), .readData(readData),
        .pins(link));
    flash_reset_device #(.PWR_UP_CYCLES(PWR)) flash_reset_device_i (.core_clk(core_clk),
        .rst(rst), .supplyOk(supplyOk), .coldFail(coldFail), .driveReq(driveReq),
        .driveBit(driveBit), .opReady(opReady), .inReset(inReset),
        .regsRestored(regsRestored), .selActive(selActive), .pins(link));
    // Second device end, its pins driven by the bench in place of a host
    flash_reset_device #(.PWR_UP_CYCLES(PWR)) flash_reset_device_i2 (.core_clk(core_clk),
        .rst(rst2), .supplyOk(supplyOk), .coldFail(coldFail2), .driveReq(driveReq),
        .driveBit(driveBit), .opReady(opReady2), .inReset(inReset2),
        .regsRestored(regsRestored2), .selActive(selActive2), .pins(bad));
    flash_reset_monitor #(.PWR_UP_CYCLES(PWR)) flash_reset_monitor_i (.core_clk(core_clk),
        .rst(rst), .selectN(link.selectN), .warmInitN(link.warmInitN),
        .dataOutEnN(link.dataOutEnN));

    // Clock source
    initial
    begin
        core_clk = 1'h0;
        forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard, far above the expected run length
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            $display("BAD %0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic ck(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    // Count compare, for latencies measured by the bench itself
    task automatic ckr(input int got, input int lo, input int hi, input string what);
        comparisons++;
        if (got < lo || got > hi)
        begin
            mismatches++;
            $display("BAD %0t %s took %0d", $time, what, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Low pulse on the bench-driven reset pin, width in cycles
    task automatic pin_pulse(input int width);
        bad.warmInitN <= 1'h0;
        cyc(width);
        bad.warmInitN <= 1'h1;
    endtask

    // One-cycle warm reset request to the host end
    task automatic warm_request();
        warmReq <= 1'h1;
        cyc(1);
        warmReq <= 1'h0;
    endtask

    // Main sequence; checks sit 1 ns after an edge, drives right on it
    initial
    begin
        int n;
        rst = 1'h1; rst2 = 1'h1; supplyOk = 1'h0; coldFail = 1'h0; coldFail2 = 1'h1;
        // Host keeps its reset pin low through power-up until holdInit drops
        holdInit = 1'h1; selReq = 1'h0; warmReq = 1'h0; driveReq = 1'h0; driveBit = 1'h0;
        bad.selectN = 1'h1; bad.warmInitN = 1'h1;
        mismatches = 0; comparisons = 0; cycles = 0;
        cyc(10); rst <= 1'h0; rst2 <= 1'h0; supplyOk <= 1'h1;
        // Pin pulse inside cold init must not matter
        cyc(10); bad.warmInitN <= 1'h0;
        cyc(5); #1 ck(opReady, 1'h0, "ready during cold init");
        cyc(5); bad.warmInitN <= 1'h1;
        cyc(40); #1 ck(inReset2, 1'h0, "cold init overran");
        ck(inReset, 1'h1, "host-held pin ignored at cold end");
        ck(opReady2, 1'h1, "pin low in cold init took effect");
        // Failed cold init: next pulse reruns the short cold count, not warm
        cyc(5); coldFail2 <= 1'h0;
        pin_pulse(10);
        #1 for (n = 10; n < 800 && opReady2 !== 1'h1; n++) #(CLK_PERIOD_NS);
        ckr(n, PWR, PWR + 30, "cold rerun after failure");
        // Glitch shorter than the pulse width is no reset
        cyc(20); pin_pulse(2);
        cyc(10); #1 ck(opReady2, 1'h1, "short pulse reset the device");
        // Pin held low through cold end keeps reset until release
        cyc(1); bad.warmInitN <= 1'h0; rst2 <= 1'h1;
        cyc(2); rst2 <= 1'h0;
        cyc(PWR + 20); #1 ck(inReset2, 1'h1, "left reset while pin low");
        cyc(1); bad.warmInitN <= 1'h1;
        cyc(20); #1 ck(opReady2, 1'h1, "no standby after release");
        ck(bad.dataOutEnN, 1'h1, "outputs driven in standby");
        cyc(1); bad.selectN <= 1'h0; driveReq <= 1'h1;
        cyc(6); #1 ck(bad.dataLine, 1'h0, "no drive when selected");
        ck(selActive2, 1'h1, "bench select not served");
        cyc(1); bad.selectN <= 1'h1; driveReq <= 1'h0;
        // Host must sit out power-up, then stay held until holdInit drops
        while (cycles < POWER_UP_CYC - 5) @(posedge core_clk);
        #1 ck(hostReady, 1'h0, "host ready inside power-up");
        ck(link.selectN, 1'h1, "select low inside power-up");
        cyc(25); #1 ck(hostReady, 1'h0, "host ready while pin held");
        ck(link.warmInitN, 1'h0, "pin not held low");
        ck(inReset, 1'h1, "left reset while pin held");
        cyc(1); holdInit <= 1'h0;
        #1 for (n = 0; n < 100 && hostReady !== 1'h1; n++) #(CLK_PERIOD_NS);
        ckr(n, HOST_RELEASE_CYC + 1, HOST_RELEASE_CYC + 1, "host release wait");
        cyc(1); selReq <= 1'h1;
        cyc(8); #1 ck(selActive, 1'h1, "select not served");
        ck(opReady, 1'h1, "no standby after pin release");
        ck(link.dataOutEnN, 1'h1, "driven without request");
        cyc(1); driveReq <= 1'h1;
        cyc(6); #1 ck(readData, 1'h0, "data bit lost");
        // Warm reset while selected
        cyc(1); warm_request();
        cyc(1); #1 ck(link.warmInitN, 1'h0, "pin not low");
        ck(link.selectN, 1'h1, "select not raised");
        cyc(9); #1 ck(inReset, 1'h1, "warm reset not entered");
        ck(link.dataOutEnN, 1'h1, "outputs not released");
        for (n = 10; n < 1000 && regsRestored !== 1'h1; n++) #(CLK_PERIOD_NS);
        ckr(n, WARM_RECOVERY_CYC, WARM_RECOVERY_CYC + SYNC_LAT_CYC + 12, "warm recovery");
        for (n = 0; n < 100 && hostReady !== 1'h1; n++) #(CLK_PERIOD_NS);
        cyc(8); #1 ck(readData, 1'h0, "no service after warm reset");
        tally_and_finish();
    end
endmodule

// ==== verilog/flash_reset_device.sv ====
// Device end: cold and warm reset sequencing of the serial flash interface.
// Pins arrive from the host asynchronously; supply-good comes from an analog monitor.
// What this block and the host end do
// R01: Cold init runs, finishes before any operation
// R02: Cold init lasts the power-up interval
// R03: Host keeps select high during power-up
// R04: Warm reset pin ignored during cold init
// R05: Pin low at power-up end holds reset
// R06: Host selects only after release delay
// R07: Host holds pin high for setup time
// R08: Falling pin restores registers within recovery
// R09: Failed cold init restarts full cold init
// R10: Long low pulse aborts, tri-states, blocks commands
// R11: Host raises select during warm recovery
// R12: Host pulse plus delay covers recovery
// R13: After reset, idle standby, outputs released
`timescale 1ns/1ps
module flash_reset_device #(
    parameter int PWR_UP_CYCLES = flash_reset_pkg::POWER_UP_CYC
) (
    input  wire logic    core_clk,
    input  wire logic    rst,
    input  wire logic    supplyOk,
    input  wire logic    coldFail,
    input  wire logic    driveReq,
    input  wire logic    driveBit,
    output logic         opReady,
    output logic         inReset,
    output logic         regsRestored,
    output logic         selActive,
    flash_reset_if.device pins
);
    import flash_reset_pkg::*;

    dev_state_type    state_ff;
    dev_state_type    nxt_state;
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic             coldOk_ff;
    logic             nxt_coldOk;
    logic             dataOut_ff;
    logic             nxt_dataOut;
    logic             dataOutEnN_ff;
    logic             nxt_dataOutEnN;
    logic             nxt_opReady;
    logic             nxt_inReset;
    logic             nxt_regsRestored;
    logic             nxt_selActive;

    // Synchroniser stages; first stage feeds only the second
    logic             supSync1_ff;
    logic             supSync2_ff;
    logic             selSync1_ff;
    logic             selSync2_ff;
    logic             initSync1_ff;
    logic             initSync2_ff;
    logic             initPrev_ff;
    logic             initFall;

    assign pins.dataOut    = dataOut_ff;
    assign pins.dataOutEnN = dataOutEnN_ff;

    // Falling edge of the synchronised warm reset pin
    assign initFall = initPrev_ff & ~initSync2_ff;

    // Count limit check, shared by cold and warm timing
    function automatic logic count_done(input logic [CNT_W-1:0] cnt, input int limit);
        return cnt >= CNT_W'(limit - 1);
    endfunction

    // Sequencer next state
    always_comb
    begin
        nxt_state        = state_ff;
        nxt_count        = count_ff + 13'h1;
        nxt_coldOk       = coldOk_ff;
        nxt_dataOut      = 1'h0;
        nxt_dataOutEnN   = PIN_HIGH;
        nxt_opReady      = 1'h0;
        nxt_inReset      = 1'h1;
        nxt_regsRestored = 1'h0;
        nxt_selActive    = 1'h0;
        unique case (state_ff)
            DEV_OFF:
            begin
                // Supply below threshold; nothing runs
                nxt_count = '0;
                if (supSync2_ff)
                    nxt_state = DEV_COLD;
            end
            DEV_COLD:
            begin
                // R04: pin state looked at only once the count ends
                // R02: full power-up interval
                if (count_done(count_ff, PWR_UP_CYCLES))
                begin
                    nxt_count        = '0;
                    nxt_coldOk       = ~coldFail;
                    nxt_regsRestored = 1'h1;
                    // R05: pin still low holds reset
                    nxt_state        = initSync2_ff ? DEV_STANDBY : DEV_HELD;
                end
            end
            DEV_HELD:
            begin
                nxt_count = '0;
                if (initSync2_ff)
                    nxt_state = DEV_STANDBY;
            end
            DEV_STANDBY, DEV_ACTIVE:
            begin
                // R13: idle with outputs released
                nxt_count   = '0;
                nxt_inReset = 1'h0;
                nxt_opReady = 1'h1;
                // R01: operations only after cold init
                if (!selSync2_ff)
                begin
                    nxt_state      = DEV_ACTIVE;
                    nxt_selActive  = 1'h1;
                    nxt_dataOut    = driveBit;
                    nxt_dataOutEnN = ~driveReq;
                end
                else
                begin
                    nxt_state = DEV_STANDBY;
                end
                if (initFall)
                begin
                    nxt_opReady    = 1'h0;
                    nxt_selActive  = 1'h0;
                    nxt_dataOut    = 1'h0;
                    nxt_dataOutEnN = PIN_HIGH;
                    nxt_count      = 13'h1;
                    // R09: failed cold init goes cold again
                    nxt_state      = coldOk_ff ? DEV_PULSE : DEV_COLD;
                end
            end
            DEV_PULSE:
            begin
                // Short glitches are not a reset; a held select keeps working
                nxt_inReset = 1'h0;
                nxt_opReady = 1'h1;
                if (!selSync2_ff)
                begin
                    nxt_selActive  = 1'h1;
                    nxt_dataOut    = driveBit;
                    nxt_dataOutEnN = ~driveReq;
                end
                if (initSync2_ff)
                begin
                    nxt_count = '0;
                    nxt_state = DEV_STANDBY;
                end
                // R10: held long enough, abort and tri-state
                else if (count_done(count_ff, INIT_PULSE_CYC))
                begin
                    nxt_inReset    = 1'h1;
                    nxt_opReady    = 1'h0;
                    nxt_selActive  = 1'h0;
                    nxt_dataOutEnN = PIN_HIGH;
                    nxt_state      = DEV_WARM;
                end
            end
            DEV_WARM:
            begin
                // R10: commands ignored through recovery
                // R08: registers restored by recovery end
                if (count_done(count_ff, WARM_RECOVERY_CYC))
                begin
                    nxt_count        = count_ff;
                    nxt_regsRestored = initSync2_ff;
                    if (initSync2_ff)
                    begin
                        nxt_count = '0;
                        nxt_state = DEV_STANDBY;
                    end
                end
            end
            default:
            begin
                nxt_state = DEV_OFF;
                nxt_count = '0;
            end
        endcase
        // Supply loss drops everything back to off
        if (!supSync2_ff)
        begin
            nxt_state        = DEV_OFF;
            nxt_count        = '0;
            nxt_coldOk       = 1'h0;
            nxt_opReady      = 1'h0;
            nxt_inReset      = 1'h1;
            nxt_selActive    = 1'h0;
            nxt_regsRestored = 1'h0;
            nxt_dataOutEnN   = PIN_HIGH;
            nxt_dataOut      = 1'h0;
        end
    end

    // Sequencer registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_ff      <= DEV_OFF;
            count_ff      <= '0;
            coldOk_ff     <= 1'h0;
            dataOut_ff    <= 1'h0;
            dataOutEnN_ff <= PIN_HIGH;
            opReady       <= 1'h0;
            inReset       <= 1'h1;
            regsRestored  <= 1'h0;
            selActive     <= 1'h0;
        end
        else
        begin
            state_ff      <= nxt_state;
            count_ff      <= nxt_count;
            coldOk_ff     <= nxt_coldOk;
            dataOut_ff    <= nxt_dataOut;
            dataOutEnN_ff <= nxt_dataOutEnN;
            opReady       <= nxt_opReady;
            inReset       <= nxt_inReset;
            regsRestored  <= nxt_regsRestored;
            selActive     <= nxt_selActive;
        end
    end

    // Pin synchronisers; pins idle high, supply idles low
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            supSync1_ff  <= 1'h0;
            supSync2_ff  <= 1'h0;
            selSync1_ff  <= PIN_HIGH;
            selSync2_ff  <= PIN_HIGH;
            initSync1_ff <= PIN_HIGH;
            initSync2_ff <= PIN_HIGH;
            initPrev_ff  <= PIN_HIGH;
        end
        else
        begin
            supSync1_ff  <= supplyOk;
            supSync2_ff  <= supSync1_ff;
            selSync1_ff  <= pins.selectN;
            selSync2_ff  <= selSync1_ff;
            initSync1_ff <= pins.warmInitN;
            initSync2_ff <= initSync1_ff;
            initPrev_ff  <= initSync2_ff;
        end
    end
endmodule

// ==== verilog/flash_reset_host.sv ====
// Host end: sequences select and warm reset pins around power-up and warm resets.
// Assumes rst marks power applied to both ends and a 20 MHz core_clk.
`timescale 1ns/1ps
module flash_reset_host (
    input  wire logic  core_clk,
    input  wire logic  rst,
    input  wire logic  holdInit,
    input  wire logic  selReq,
    input  wire logic  warmReq,
    output logic       hostReady,
    output logic       readData,
    flash_reset_if.host pins
);
    import flash_reset_pkg::*;

    host_state_type   state_ff;
    host_state_type   nxt_state;
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic             selectN_ff;
    logic             nxt_selectN;
    logic             warmInitN_ff;
    logic             nxt_warmInitN;
    logic             nxt_hostReady;
    logic             dataSync1_ff;
    logic             dataSync2_ff;

    assign pins.selectN   = selectN_ff;
    assign pins.warmInitN = warmInitN_ff;
    assign readData       = dataSync2_ff;

    // Pin sequencing
    always_comb
    begin
        nxt_state     = state_ff;
        nxt_count     = count_ff + 13'h1;
        nxt_selectN   = selectN_ff;
        nxt_warmInitN = warmInitN_ff;
        nxt_hostReady = 1'h0;
        unique case (state_ff)
            HOST_PWRUP:
            begin
                // R03: select held off
                nxt_selectN   = PIN_HIGH;
                nxt_warmInitN = ~holdInit;
                if (count_ff >= CNT_W'(POWER_UP_CYC - 1))
                begin
                    nxt_state = holdInit ? HOST_WAITREL : HOST_RELEASE;
                    nxt_count = '0;
                end
            end
            HOST_WAITREL:
            begin
                // R06: select waits for release
                nxt_count     = '0;
                nxt_warmInitN = ~holdInit;
                if (!holdInit)
                    nxt_state = HOST_RELEASE;
            end
            HOST_IDLE:
            begin
                nxt_count     = '0;
                nxt_hostReady = ~warmReq;
                nxt_selectN   = ~selReq;
                if (warmReq)
                begin
                    // R11: raise select with reset
                    nxt_selectN   = PIN_HIGH;
                    nxt_warmInitN = 1'h0;
                    nxt_hostReady = 1'h0;
                    nxt_state     = HOST_PULSE;
                end
            end
            HOST_PULSE:
            begin
                // R12: pulse plus delay covers recovery
                if (count_ff >= CNT_W'(HOST_PULSE_CYC - 1))
                begin
                    nxt_warmInitN = PIN_HIGH;
                    nxt_count     = '0;
                    nxt_state     = HOST_RELEASE;
                end
            end
            HOST_RELEASE:
            begin
                // R07: high for setup before next
                nxt_warmInitN = PIN_HIGH;
                if (count_ff >= CNT_W'(HOST_RELEASE_CYC - 1))
                begin
                    nxt_count     = '0;
                    nxt_hostReady = 1'h1;
                    nxt_state     = HOST_IDLE;
                end
            end
            default:
            begin
                nxt_state = HOST_IDLE;
                nxt_count = '0;
            end
        endcase
    end

    // Registers, and a two-flop sync for the returning data pin
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_ff     <= HOST_PWRUP;
            count_ff     <= '0;
            selectN_ff   <= PIN_HIGH;
            warmInitN_ff <= PIN_HIGH;
            hostReady    <= 1'h0;
            dataSync1_ff <= PIN_HIGH;
            dataSync2_ff <= PIN_HIGH;
        end
        else
        begin
            state_ff     <= nxt_state;
            count_ff     <= nxt_count;
            selectN_ff   <= nxt_selectN;
            warmInitN_ff <= nxt_warmInitN;
            hostReady    <= nxt_hostReady;
            dataSync1_ff <= pins.dataLine;
            dataSync2_ff <= dataSync1_ff;
        end
    end
endmodule

// ==== verilog/flash_reset_if.sv ====
// Pins between the reset-sequencing host and the flash device end.
// The testbench instantiates this and binds both modports; data line has a pull-up.
`timescale 1ns/1ps
interface flash_reset_if;
    logic selectN;     // Device select, driven by host
    logic warmInitN;   // Warm reset pin, driven by host
    logic dataOut;     // Device serial data output
    logic dataOutEnN;  // Low while the device drives dataOut
    logic dataLine;    // Resolved wire level

    // Pull-up wins whenever the device lets go
    assign dataLine = dataOutEnN ? 1'h1 : dataOut;

    modport device (
        input  selectN,
        input  warmInitN,
        output dataOut,
        output dataOutEnN
    );

    modport host (
        output selectN,
        output warmInitN,
        input  dataLine
    );
endinterface

// ==== verilog/flash_reset_pkg.sv ====
// Constants and types shared by both ends of the flash reset link.
// Assumes one 20 MHz core clock on each end; all times become cycle counts here.
package flash_reset_pkg;

    // Core clock period
    localparam int CLK_PERIOD_NS = 50;

    // Least time in ns to whole cycles, rounded up, never below one
    function automatic int min_cycles(input int timeNs);
        int cyc;
        cyc = (timeNs + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    // Documented times, in their own units
    localparam int POWER_UP_INTERVAL_US       = 300;
    localparam int WARM_RECOVERY_TIME_US      = 35;
    localparam int REINIT_SETUP_TIME_NS       = 50;
    localparam int INIT_PULSE_WIDTH_NS        = 200;
    localparam int RELEASE_TO_SELECT_DELAY_NS = 50;

    // Derived cycle counts
    localparam int POWER_UP_CYC      = min_cycles(POWER_UP_INTERVAL_US * 1000);
    localparam int WARM_RECOVERY_CYC = min_cycles(WARM_RECOVERY_TIME_US * 1000);
    localparam int REINIT_SETUP_CYC  = min_cycles(REINIT_SETUP_TIME_NS);
    localparam int INIT_PULSE_CYC    = min_cycles(INIT_PULSE_WIDTH_NS);
    localparam int RELEASE_CYC       = min_cycles(RELEASE_TO_SELECT_DELAY_NS);

    // Two-flop pin synchroniser plus edge register on the far side
    localparam int SYNC_LAT_CYC = 3;

    // Host timing: low pulse covers recovery, release wait covers the far side latency
    localparam int HOST_PULSE_CYC   = (WARM_RECOVERY_CYC > INIT_PULSE_CYC) ?
                                      WARM_RECOVERY_CYC : INIT_PULSE_CYC;
    localparam int HOST_RELEASE_CYC = ((RELEASE_CYC > REINIT_SETUP_CYC) ?
                                      RELEASE_CYC : REINIT_SETUP_CYC) + SYNC_LAT_CYC;

    // Counter width, large enough for the power-up count
    localparam int CNT_W = 13;

    // Reset values of the pins
    localparam logic PIN_HIGH = 1'h1;

    typedef enum logic [2:0] {
        DEV_OFF     = 3'b000,
        DEV_COLD    = 3'b001,
        DEV_HELD    = 3'b010,
        DEV_STANDBY = 3'b011,
        DEV_ACTIVE  = 3'b100,
        DEV_PULSE   = 3'b101,
        DEV_WARM    = 3'b110
    } dev_state_type;

    typedef enum logic [2:0] {
        HOST_PWRUP   = 3'b000,
        HOST_WAITREL = 3'b001,
        HOST_IDLE    = 3'b010,
        HOST_PULSE   = 3'b011,
        HOST_RELEASE = 3'b100
    } host_state_type;

endpackage
